// ==== prbr_device.sv ====
`timescale 1ns/100ps
module prbr_device
    import prbr_pkg::*;
#(
    parameter int HWRST_CYC = PRBR_HWRST_CYC,
    parameter int SWRST_CYC = PRBR_SWRST_CYC
)(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    prbr_if.device mgmt,
    input wire logic [3:0] strap_i,
    output logic [3:0] strap_o,
    output logic [15:0] ctrl_o,
    output logic in_reset_o,
    output logic datapath_rst_o
);
    typedef enum logic [1:0] {ST_POR, ST_RUN, ST_FULL} prbr_st_type;
    prbr_st_type st_ff, nxt_st;
    logic [2:0] pin_ff, nxt_pin;
    logic [PRBR_CW-1:0] cnt_ff, nxt_cnt;
    logic [PRBR_CW-1:0] low_ff, nxt_low;
    logic [4:0] soft_ff, nxt_soft;
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [15:0] xctl_ff, nxt_xctl;
    logic [3:0] strap_ff, nxt_strap;
    logic ack_ff, nxt_ack;
    logic [15:0] rd_ff, nxt_rd;
    logic pin_low;
    logic acc;
    logic [3:0] strap_s0_ff, nxt_strap_s0;
    logic [3:0] strap_s1_ff, nxt_strap_s1;
    logic [3:0] strap_s2_ff, nxt_strap_s2;

    // pin counter stops at its limit; one compare shared by the por and pin counters
    function automatic logic at_lim(input logic [PRBR_CW-1:0] c,
        input int lim);
        at_lim = (c == PRBR_CW'(lim));
    endfunction

    // pin passes three flops; low once the last two both read low
    assign pin_low = ~pin_ff[1] & ~pin_ff[2];
    // requests wait unanswered outside the run state
    assign acc = mgmt.req & ~ack_ff & (st_ff == ST_RUN);

    always_comb
    begin
        nxt_pin = {pin_ff[1:0], mgmt.reset_n};
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_low = pin_low ? (at_lim(low_ff, HWRST_CYC) ? low_ff :
            low_ff + 1'b1) : '0;
        nxt_soft = (soft_ff != 5'h00) ? soft_ff - 5'h01 : 5'h00;
        nxt_ctrl = ctrl_ff;
        nxt_xctl = xctl_ff;
        nxt_strap = strap_ff;
        nxt_ack = 1'b0;
        nxt_rd = rd_ff;
        case (st_ff)
            ST_POR:
            begin
                // internal por; straps follow the pins till it ends
                nxt_cnt = cnt_ff + 1'b1;
                // whole word must agree, so one bouncing strap holds all
                if (strap_s1_ff == strap_s2_ff)
                    nxt_strap = strap_s2_ff;
                if (at_lim(cnt_ff, PRBR_POR_CYC))
                    nxt_st = ST_RUN;
            end
            ST_RUN:
            begin
                if (acc)
                begin
                    nxt_ack = 1'b1;
                    if (mgmt.we)
                    begin
                        if (mgmt.addr == PRBR_OFF_CTRL)
                        begin
                            nxt_ctrl = mgmt.wdata;
                            if (mgmt.wdata[PRBR_BIT_FULL_RST])
                            begin
                                nxt_st = ST_FULL;
                                nxt_cnt = '0;
                            end
                        end
                        else if (mgmt.addr == PRBR_OFF_XCTL2)
                        begin
                            // soft bit is a strobe; others kept
                            nxt_xctl = mgmt.wdata;
                            nxt_xctl[PRBR_BIT_SOFT_RST] = 1'b0;
                            if (mgmt.wdata[PRBR_BIT_SOFT_RST])
                                nxt_soft = 5'(PRBR_SOFT_CYC);
                        end
                        // status and ids ignore writes
                    end
                    else
                    begin
                        case (mgmt.addr)
                            PRBR_OFF_CTRL: nxt_rd = ctrl_ff;
                            PRBR_OFF_STAT: nxt_rd = PRBR_STAT_VAL;
                            PRBR_OFF_ID1: nxt_rd = PRBR_ID1_VAL;
                            PRBR_OFF_ID2: nxt_rd = PRBR_ID2_VAL;
                            PRBR_OFF_XCTL2: nxt_rd = xctl_ff;
                            default: nxt_rd = 16'h0000;
                        endcase
                    end
                end
            end
            ST_FULL:
            begin
                // registers to defaults, straps untouched
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= PRBR_CW'(SWRST_CYC - 1))
                begin
                    nxt_ctrl = PRBR_CTRL_RST; // bit 15 clears
                    nxt_xctl = PRBR_XCTL2_RST;
                    nxt_soft = 5'h00;
                    nxt_st = ST_RUN;
                end
            end
            default: nxt_st = ST_POR;
        endcase
        // pin reset held 1 us acts like power-up
        if (at_lim(low_ff, HWRST_CYC))
        begin
            nxt_st = ST_POR;
            nxt_cnt = '0;
            nxt_ctrl = PRBR_CTRL_RST;
            nxt_xctl = PRBR_XCTL2_RST;
            nxt_soft = 5'h00;
            nxt_ack = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_ff <= ST_POR;
            pin_ff <= 3'h7;
            cnt_ff <= '0;
            low_ff <= '0;
            soft_ff <= 5'h00;
            ctrl_ff <= PRBR_CTRL_RST;
            xctl_ff <= PRBR_XCTL2_RST;
            strap_ff <= 4'h0;
            ack_ff <= 1'b0;
            rd_ff <= 16'h0000;
        end
        else
        begin
            st_ff <= nxt_st;
            pin_ff <= nxt_pin;
            cnt_ff <= nxt_cnt;
            low_ff <= nxt_low;
            soft_ff <= nxt_soft;
            ctrl_ff <= nxt_ctrl;
            xctl_ff <= nxt_xctl;
            strap_ff <= nxt_strap;
            ack_ff <= nxt_ack;
            rd_ff <= nxt_rd;
        end
    end

    // straps are pins: two flops before anything reads them
    always_comb
    begin
        nxt_strap_s0 = strap_i;
        nxt_strap_s1 = strap_s0_ff;
        nxt_strap_s2 = strap_s1_ff;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            strap_s0_ff <= 4'h0;
            strap_s1_ff <= 4'h0;
            strap_s2_ff <= 4'h0;
        end
        else
        begin
            strap_s0_ff <= nxt_strap_s0;
            strap_s1_ff <= nxt_strap_s1;
            strap_s2_ff <= nxt_strap_s2;
        end
    end

    assign mgmt.ack = ack_ff;
    assign mgmt.rdata = rd_ff;
    assign strap_o = strap_ff;
    assign ctrl_o = ctrl_ff;
    assign in_reset_o = (st_ff != ST_RUN);
    assign datapath_rst_o = (st_ff != ST_RUN) | (soft_ff != 5'h00);
endmodule

// ==== prbr_pkg.sv ====
package prbr_pkg;
    localparam int PRBR_AW = 5;
    localparam int PRBR_DW = 16;
    // management offsets
    localparam logic [4:0] PRBR_OFF_CTRL = 5'h00;
    localparam logic [4:0] PRBR_OFF_STAT = 5'h01;
    localparam logic [4:0] PRBR_OFF_ID1 = 5'h02;
    localparam logic [4:0] PRBR_OFF_ID2 = 5'h03;
    localparam logic [4:0] PRBR_OFF_XCTL2 = 5'h1C;
    // field positions
    localparam int PRBR_BIT_FULL_RST = 15;
    localparam int PRBR_BIT_SOFT_RST = 9;
    // reset values
    localparam logic [15:0] PRBR_CTRL_RST = 16'h3100;
    localparam logic [15:0] PRBR_STAT_VAL = 16'h7849;
    localparam logic [15:0] PRBR_XCTL2_RST = 16'h0000;
    // arbitrary identifier values
    localparam logic [15:0] PRBR_ID1_VAL = 16'h1234;
    localparam logic [15:0] PRBR_ID2_VAL = 16'h5670;
    // timing, counter width and host register numbers
    localparam int PRBR_CLK_MHZ = 200;
    localparam int PRBR_POR_NS = 100;
    localparam int PRBR_POR_CYC = PRBR_POR_NS * PRBR_CLK_MHZ / 1000;
    localparam int PRBR_HWRST_NS = 1000;
    localparam int PRBR_HWRST_CYC =
        (PRBR_HWRST_NS * PRBR_CLK_MHZ + 999) / 1000;
    localparam int PRBR_SWRST_NS = 1000;
    localparam int PRBR_SWRST_CYC = PRBR_SWRST_NS * PRBR_CLK_MHZ / 1000;
    localparam int PRBR_SWWAIT_NS = 3000;
    localparam int PRBR_SWWAIT_CYC =
        (PRBR_SWWAIT_NS * PRBR_CLK_MHZ + 999) / 1000;
    localparam int PRBR_SOFT_CYC = 16;
    localparam int PRBR_CW = 12;
    localparam logic [1:0] PRBR_REG_CTRL = 2'h0;
    localparam logic [1:0] PRBR_REG_CMD = 2'h1;
    localparam logic [1:0] PRBR_REG_STAT = 2'h2;
    localparam logic [1:0] PRBR_REG_RD = 2'h3;
endpackage

// ==== prbr_if.sv ====
`timescale 1ns/100ps
interface prbr_if;
    logic reset_n;
    logic req;
    logic we;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport device (
        input reset_n, req, we, addr, wdata,
        output ack, rdata
    );
    modport host (
        output reset_n, req, we, addr, wdata,
        input ack, rdata
    );
endinterface

// ==== prbr_host.sv ====
`timescale 1ns/100ps
// host: avalon slave; regs 0 ctrl, 1 cmd, 2 status, 3 read data
module prbr_host
    import prbr_pkg::*;
#(
    parameter int HWRST_CYC = PRBR_HWRST_CYC,
    parameter int SWWAIT_CYC = PRBR_SWWAIT_CYC
)(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    prbr_if.host mgmt
);
    typedef enum logic [1:0] {H_IDLE, H_PIN, H_BUSY, H_WAIT} prbr_hst_type;
    prbr_hst_type st_ff, nxt_st;
    logic [PRBR_CW-1:0] cnt_ff, nxt_cnt;
    logic req_ff, nxt_req;
    logic we_ff, nxt_we;
    logic [4:0] addr_ff, nxt_addr;
    logic [15:0] wd_ff, nxt_wd;
    logic [15:0] rd_ff, nxt_rd;
    logic [31:0] ao_ff, nxt_ao;
    logic wt_ff, nxt_wt;
    logic full_hit;

    // full reset written: host holds off requests for 3 us
    assign full_hit = we_ff & (addr_ff == PRBR_OFF_CTRL) &
        wd_ff[PRBR_BIT_FULL_RST];

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_req = req_ff;
        nxt_we = we_ff;
        nxt_addr = addr_ff;
        nxt_wd = wd_ff;
        nxt_rd = rd_ff;
        nxt_ao = ao_ff;
        nxt_wt = 1'b1;
        case (st_ff)
            H_IDLE:
            begin
                if (avs_write_i && !wt_ff)
                    nxt_wt = 1'b1;
                else if (avs_write_i && avs_address_i == PRBR_REG_CMD)
                begin
                    nxt_wt = 1'b0;
                    if (avs_writedata_i[31])
                    begin
                        nxt_st = H_PIN;
                        nxt_cnt = '0;
                    end
                    else
                    begin
                        nxt_we = avs_writedata_i[21];
                        nxt_addr = avs_writedata_i[20:16];
                        nxt_wd = avs_writedata_i[15:0];
                        nxt_req = 1'b1;
                        nxt_st = H_BUSY;
                    end
                end
                else if (avs_write_i || avs_read_i)
                begin
                    nxt_wt = 1'b0;
                    case (avs_address_i)
                        PRBR_REG_STAT: nxt_ao = 32'h0;
                        PRBR_REG_RD: nxt_ao = {16'h0000, rd_ff};
                        default: nxt_ao = 32'h0;
                    endcase
                end
            end
            H_PIN:
            begin
                // pin low at least 1 us
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= PRBR_CW'(HWRST_CYC + 2))
                    nxt_st = H_IDLE;
            end
            H_BUSY:
            begin
                if (mgmt.ack)
                begin
                    nxt_req = 1'b0;
                    nxt_rd = mgmt.rdata;
                    nxt_cnt = '0;
                    nxt_st = full_hit ? H_WAIT : H_IDLE;
                end
            end
            H_WAIT:
            begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff >= PRBR_CW'(SWWAIT_CYC))
                    nxt_st = H_IDLE;
            end
            default: nxt_st = H_IDLE;
        endcase
        if (st_ff != H_IDLE)
            nxt_wt = 1'b1;
        if (avs_read_i && !wt_ff)
            nxt_wt = 1'b1;
        if (st_ff != H_IDLE && (avs_read_i || avs_write_i) && wt_ff &&
            avs_address_i == PRBR_REG_STAT && !avs_write_i)
        begin
            nxt_wt = 1'b0;
            nxt_ao = 32'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_ff <= H_IDLE;
            cnt_ff <= '0;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            addr_ff <= 5'h00;
            wd_ff <= 16'h0000;
            rd_ff <= 16'h0000;
            ao_ff <= 32'h0;
            wt_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            req_ff <= nxt_req;
            we_ff <= nxt_we;
            addr_ff <= nxt_addr;
            wd_ff <= nxt_wd;
            rd_ff <= nxt_rd;
            ao_ff <= nxt_ao;
            wt_ff <= nxt_wt;
        end
    end

    assign avs_waitrequest_o = wt_ff;
    assign avs_readdata_o = ao_ff;
    assign mgmt.reset_n = (st_ff != H_PIN);
    assign mgmt.req = req_ff;
    assign mgmt.we = we_ff;
    assign mgmt.addr = addr_ff;
    assign mgmt.wdata = wd_ff;
endmodule

// ==== prbr_checker.sv ====
`timescale 1ns/100ps
module prbr_checker
    import prbr_pkg::*;
#(
    parameter int HWRST_CYC = PRBR_HWRST_CYC,
    parameter int SWWAIT_CYC = PRBR_SWWAIT_CYC
)(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic reset_n,
    input wire logic req,
    input wire logic we,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata
);
    // generous: covers full reset hold with shortened counts
    localparam int ACK_MAX = 300;
    logic [15:0] low_ff, nxt_low, wait_ff, nxt_wait;
    logic dflt_ff, nxt_dflt, ctl_wr, rd_ack;
    assign ctl_wr = ack && we && addr == PRBR_OFF_CTRL;
    assign rd_ack = ack && !we;
    always_comb
    begin
        nxt_low = reset_n ? 16'h0000 : low_ff + 16'h0001;
        nxt_wait = (wait_ff != 16'h0000) ? wait_ff - 16'h0001 : wait_ff;
        if (ctl_wr && wdata[PRBR_BIT_FULL_RST])
        begin
            nxt_wait = 16'(SWWAIT_CYC - 1);
        end
        nxt_dflt = ctl_wr ? wdata[PRBR_BIT_FULL_RST] : dflt_ff;
        if (!reset_n)
        begin
            nxt_dflt = 1'b1;
        end
    end
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            low_ff <= 16'h0000;
            wait_ff <= 16'h0000;
            dflt_ff <= 1'b1;
        end
        else
        begin
            low_ff <= nxt_low;
            wait_ff <= nxt_wait;
            dflt_ff <= nxt_dflt;
        end
    end
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    property p_pin_low_len;
        $rose(reset_n) |-> low_ff >= 16'(HWRST_CYC);
    endproperty
    a_pin_low_len: assert property (p_pin_low_len)
        else $error("pin reset pulse too short");
    property p_wait_after_full;
        wait_ff != 16'h0000 |-> !req;
    endproperty
    a_wait_after_full: assert property (p_wait_after_full)
        else $error("request too soon after full reset");
    property p_stat_ro;
        rd_ack && addr == PRBR_OFF_STAT |-> rdata == PRBR_STAT_VAL;
    endproperty
    a_stat_ro: assert property (p_stat_ro)
        else $error("status read wrong");
    property p_id_ro;
        rd_ack && (addr == PRBR_OFF_ID1 || addr == PRBR_OFF_ID2) |->
            rdata == (addr == PRBR_OFF_ID1 ? PRBR_ID1_VAL : PRBR_ID2_VAL);
    endproperty
    a_id_ro: assert property (p_id_ro)
        else $error("identifier read wrong");
    property p_full_bit_clear;
        rd_ack && addr == PRBR_OFF_CTRL |-> !rdata[PRBR_BIT_FULL_RST];
    endproperty
    a_full_bit_clear: assert property (p_full_bit_clear)
        else $error("full reset bit read as set");
    property p_defaults;
        rd_ack && addr == PRBR_OFF_CTRL && dflt_ff |-> rdata == PRBR_CTRL_RST;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("control not at default after reset");
    property p_answer_bound;
        req && !ack |-> ##[1:ACK_MAX] ack;
    endproperty
    a_answer_bound: assert property (p_answer_bound)
        else $error("request not answered");
    property p_ack_pulse;
        ack |-> req ##1 !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("answer not a single pulse");
endmodule

// ==== prbr_test.sv ====
`timescale 1ns/100ps
`define CHK(a, b) cmp(32'(a), 32'(b))
module prbr_test
    import prbr_pkg::*;
    ;
    localparam int HW = 8;
    localparam int SW = 8;
    localparam int SWW = 20;
    logic clk_sys_i, nrst_i, av_rd, av_wr, av_wait, in_rst, dp_rst;
    logic [1:0] av_addr;
    logic [31:0] av_wdata, av_rdata, rd;
    logic [3:0] strap_i, strap_o;
    logic [15:0] ctrl_o;
    int errors = 0, checked = 0, in_cnt = 0, dp_cnt = 0, base;
    prbr_if mgmt();
    prbr_host #(.HWRST_CYC(HW), .SWWAIT_CYC(SWW)) u_prbr_host (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(av_addr),
        .avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
        .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
        .mgmt(mgmt.host));
    prbr_device #(.HWRST_CYC(HW), .SWRST_CYC(SW)) u_prbr_device (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .mgmt(mgmt.device),
        .strap_i(strap_i), .strap_o(strap_o), .ctrl_o(ctrl_o),
        .in_reset_o(in_rst), .datapath_rst_o(dp_rst));
    prbr_checker #(.HWRST_CYC(HW), .SWWAIT_CYC(SWW)) u_prbr_checker (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reset_n(mgmt.reset_n),
        .req(mgmt.req), .we(mgmt.we), .addr(mgmt.addr),
        .wdata(mgmt.wdata), .ack(mgmt.ack), .rdata(mgmt.rdata));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i)
    begin
        in_cnt <= in_cnt + int'(in_rst);
        dp_cnt <= dp_cnt + int'(dp_rst);
    end
    task cmp(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    // holds the request until the edge that sees waitrequest low
    task av(input logic w, input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        av_addr <= a;
        av_wdata <= d;
        av_wr <= w;
        av_rd <= !w;
        do @(posedge clk_sys_i); while (av_wait !== 1'b0);
        rd = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task poll;
        do av(1'b0, 2'h2, 32'h0); while (rd[0] !== 1'b0);
    endtask
    task mw(input logic [4:0] a, input logic [15:0] d);
        av(1'b1, 2'h1, {10'h000, 1'b1, a, d});
        poll;
    endtask
    task mr(input logic [4:0] a);
        av(1'b1, 2'h1, {11'h000, a, 16'h0000});
        poll;
        av(1'b0, 2'h3, 32'h0);
    endtask
    task end_of_test;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100000;
        errors++;
        end_of_test;
    end
    initial
    begin
        nrst_i = 1'b0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_addr = 2'h0;
        av_wdata = 32'h0;
        strap_i = 4'hA;
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        `CHK(in_rst, 1'b0);
        `CHK(ctrl_o, PRBR_CTRL_RST);
        `CHK(strap_o, 4'hA);
        av(1'b0, 2'h0, 32'h0);
        `CHK(rd, 32'h0);
        mw(PRBR_OFF_CTRL, 16'h1140);
        mr(PRBR_OFF_CTRL);
        `CHK(rd[15:0], 16'h1140);
        mw(PRBR_OFF_STAT, 16'hFFFF);
        mr(PRBR_OFF_STAT);
        `CHK(rd[15:0], PRBR_STAT_VAL);
        for (int i = 0; i < 2; i++)
        begin
            mw(PRBR_OFF_ID1 + 5'(i), 16'h0000);
            mr(PRBR_OFF_ID1 + 5'(i));
            `CHK(rd[15:0], i ? PRBR_ID2_VAL : PRBR_ID1_VAL);
        end
        base = dp_cnt;
        mw(PRBR_OFF_XCTL2, 16'(1 << PRBR_BIT_SOFT_RST));
        repeat (20) @(posedge clk_sys_i);
        `CHK(dp_cnt - base, PRBR_SOFT_CYC);
        mr(PRBR_OFF_CTRL);
        `CHK(rd[15:0], 16'h1140);
        `CHK(ctrl_o, 16'h1140);
        strap_i <= 4'h5;
        base = in_cnt;
        mw(PRBR_OFF_CTRL, 16'(1 << PRBR_BIT_FULL_RST));
        `CHK(in_cnt - base, SW);
        mr(PRBR_OFF_CTRL);
        `CHK(rd[15:0], PRBR_CTRL_RST);
        `CHK(strap_o, 4'hA);
        mw(PRBR_OFF_CTRL, 16'h1140);
        av(1'b1, 2'h1, 32'h8000_0000);
        poll;
        repeat (40) @(posedge clk_sys_i);
        mr(PRBR_OFF_CTRL);
        `CHK(rd[15:0], PRBR_CTRL_RST);
        `CHK(strap_o, 4'h5);
        end_of_test;
    end
endmodule
